// ==== design/sts_gate.sv ====
// commitment gate: decides whether a split request fits within a limit
// assumes outstanding and request sizes counted in ADQs
`timescale 1ns/100ps
`default_nettype none
module sts_gate
  import sts_pkg::*;
(
  input  wire logic [15:0] limit,
  input  wire logic [15:0] used,
  input  wire logic [15:0] req_size,
  output logic             fits
);
`include "sts_map.svh"
  logic [16:0] total;
  always_comb begin
    total = {1'b0, used} + {1'b0, req_size};
    // all-ones means no ceiling at all
    fits  = (limit == `STS_LIM_ALL) || (total <= {1'b0, limit});
  end
endmodule // sts_gate
`default_nettype wire

// ==== design/sts_idcap.sv ====
// identity capture from type 0 configuration writes
// assumes cfg strobes are one-cycle pulses in sys_clk
`timescale 1ns/100ps
`default_nettype none
module sts_idcap
  import sts_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        cfg_wr,
  input  wire logic [15:0] cfg_addr,
  output logic [4:0]       dev_num
);
`include "sts_map.svh"
  typedef struct packed {
    logic [4:0] dev;
  } sts_id_s;
  sts_id_s st_q, st_d;
  always_comb begin
    st_d = st_q;
    if (cfg_wr) begin
      st_d.dev = cfg_addr[15:11];
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q.dev <= `STS_DEV_RST;
    end else begin
      st_q <= st_d;
    end
  end
  assign dev_num = st_q.dev;
endmodule // sts_idcap
`default_nettype wire

// ==== design/sts_map.svh ====
// constants for the split-transaction status and control block
// assumes a configuration-space register port in sys_clk domain
`ifndef STS_MAP_SVH
`define STS_MAP_SVH
`define STS_OFS_STATUS   8'h84
`define STS_OFS_UP       8'h88
`define STS_OFS_DN       8'h8c
`define STS_OFS_PM       8'h90
`define STS_BIT_133      17
`define STS_BIT_DISC     18
`define STS_BIT_UNEXP    19
`define STS_BIT_OVR      20
`define STS_BIT_DLY      21
`define STS_CAP_RST      16'h0010
`define STS_LIM_RST      16'h0010
`define STS_LIM_ALL      16'hffff
`define STS_PM_ID        8'h01
`define STS_DEV_RST      5'h1f
`define STS_BUS_RST      8'hff
`define STS_FUNC_RST     3'h0
`endif

// ==== design/sts_pkg.sv ====
// types for the split-transaction status and control block
// assumes sts_map.svh holds the numbers
package sts_pkg;
  typedef enum logic [0:0] {
    STS_FWD = 1'b0,
    STS_REV = 1'b1
  } sts_mode_e;
  typedef logic [15:0] sts_adq_t;
endpackage

// ==== design/sts_top.sv ====
// split-transaction status and control registers of the bridge
// assumes cfg_wr/cfg_rd pulses from the primary config decoder, one cycle each;
// event inputs are one-cycle pulses from the datapath in sys_clk domain
`timescale 1ns/100ps
`default_nettype none
module sts_top
  import sts_pkg::*;
#(
  parameter int CAP_UP = 16,
  parameter int CAP_DN = 16
)(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        rev_mode,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [15:0] cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic [3:0]  cfg_be,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_rvalid,
  input  wire logic        ev_cpl_discard,
  input  wire logic        cpl_in,
  input  wire logic [15:0] cpl_req_id,
  input  wire logic        cpl_matched,
  input  wire logic        ev_cpl_overrun,
  input  wire logic        req_up,
  input  wire logic        req_dn,
  input  wire logic [15:0] req_size,
  input  wire logic [15:0] used_up,
  input  wire logic [15:0] used_dn,
  output logic             fwd_up,
  output logic             fwd_dn,
  output logic [15:0]      own_id
);
`include "sts_map.svh"
  // capacity fields are fixed constants, so only 16 is served
  if (CAP_UP != 16 || CAP_DN != 16) begin : g_cap_chk
    $error("capacity other than 16 ADQs not supported");
  end

  typedef struct packed {
    logic        strap_done;
    logic        cap133;
    logic        disc;
    logic        unexp;
    logic        ovr;
    logic        dly;
    logic [15:0] lim_up;
    logic [15:0] lim_dn;
    logic [31:0] rdata;
    logic        rvalid;
  } sts_st_s;

  sts_st_s     st_q, st_d;
  logic [4:0]  dev_num;
  logic        fit_up;
  logic        fit_dn;
  logic        hit;
  logic [7:0]  ofs;
  logic        unexp_ev;
  logic        dly_ev;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;
  sts_mode_e   mode;

  sts_idcap u_idcap (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .cfg_wr   (cfg_wr),
    .cfg_addr (cfg_addr),
    .dev_num  (dev_num)
  );

  sts_gate u_gate_up (
    .limit    (st_q.lim_up),
    .used     (used_up),
    .req_size (req_size),
    .fits     (fit_up)
  );

  sts_gate u_gate_dn (
    .limit    (st_q.lim_dn),
    .used     (used_dn),
    .req_size (req_size),
    .fits     (fit_dn)
  );

  assign mode   = sts_mode_e'(rev_mode);
  assign own_id = {`STS_BUS_RST, dev_num, `STS_FUNC_RST};
  assign fwd_up = req_up & fit_up;
  assign fwd_dn = req_dn & fit_dn;
  // only the primary-bound direction counts as delayed on the primary bus
  assign dly_ev = (mode == STS_FWD) ? (req_up & ~fit_up) : (req_dn & ~fit_dn);
  assign unexp_ev = cpl_in & ~cpl_matched & (cpl_req_id == own_id);
  assign ofs = {cfg_addr[7:2], 2'b00};
  assign hit = cfg_wr & (cfg_be[2]);

  always_comb begin
    stat_word = '0;
    stat_word[`STS_BIT_133]  = st_q.cap133;
    stat_word[`STS_BIT_DISC] = st_q.disc;
    stat_word[`STS_BIT_UNEXP] = st_q.unexp;
    stat_word[`STS_BIT_OVR]  = st_q.ovr;
    stat_word[`STS_BIT_DLY]  = st_q.dly;
    stat_word[15:0] = own_id;
    stat_word[7:3]  = dev_num;
    case (ofs)
      `STS_OFS_STATUS: rd_mux = stat_word;
      `STS_OFS_UP:     rd_mux = {st_q.lim_up, `STS_CAP_RST};
      `STS_OFS_DN:     rd_mux = {st_q.lim_dn, `STS_CAP_RST};
      `STS_OFS_PM:     rd_mux = {24'h000000, `STS_PM_ID};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.rvalid = cfg_rd;
    if (cfg_rd) begin
      st_d.rdata = rd_mux;
    end
    // strap sampled once after reset release
    if (!st_q.strap_done) begin
      st_d.strap_done = 1'b1;
      st_d.cap133     = (mode == STS_REV);
    end
    // write-one-to-clear first, then events so a same-cycle set wins
    if (hit && ofs == `STS_OFS_STATUS) begin
      if (cfg_wdata[`STS_BIT_DISC])  st_d.disc  = 1'b0;
      if (cfg_wdata[`STS_BIT_UNEXP]) st_d.unexp = 1'b0;
      if (cfg_wdata[`STS_BIT_OVR])   st_d.ovr   = 1'b0;
      if (cfg_wdata[`STS_BIT_DLY])   st_d.dly   = 1'b0;
    end
    if (cfg_wr && ofs == `STS_OFS_UP) begin
      if (cfg_be[2]) st_d.lim_up[7:0]  = cfg_wdata[23:16];
      if (cfg_be[3]) st_d.lim_up[15:8] = cfg_wdata[31:24];
    end
    if (cfg_wr && ofs == `STS_OFS_DN) begin
      if (cfg_be[2]) st_d.lim_dn[7:0]  = cfg_wdata[23:16];
      if (cfg_be[3]) st_d.lim_dn[15:8] = cfg_wdata[31:24];
    end
    if (ev_cpl_discard) st_d.disc  = 1'b1;
    if (unexp_ev)       st_d.unexp = 1'b1;
    if (ev_cpl_overrun) st_d.ovr   = 1'b1;
    if (dly_ev)         st_d.dly   = 1'b1;
    // mode-locked flags read zero
    if (mode == STS_REV) st_d.disc  = 1'b0;
    if (mode == STS_FWD) st_d.unexp = 1'b0;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q.strap_done <= 1'b0;
      st_q.cap133     <= 1'b0;
      st_q.disc       <= 1'b0;
      st_q.unexp      <= 1'b0;
      st_q.ovr        <= 1'b0;
      st_q.dly        <= 1'b0;
      st_q.lim_up     <= `STS_LIM_RST;
      st_q.lim_dn     <= `STS_LIM_RST;
      st_q.rdata      <= 32'h00000000;
      st_q.rvalid     <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg_rdata  = st_q.rdata;
  assign cfg_rvalid = st_q.rvalid;

  // whole signals for $past, which must not see a slice
  logic [15:0] wr_lim;
  logic [4:0]  wr_dev;
  assign wr_lim = cfg_wdata[31:16];
  assign wr_dev = cfg_addr[15:11];

  property p_disc_set;
    @(posedge sys_clk) disable iff (reset)
      (ev_cpl_discard && mode == STS_FWD) |=> st_q.disc;
  endproperty
  a_disc_set: assert property (p_disc_set) else $error("discard flag not set");

  property p_disc_rev;
    @(posedge sys_clk) disable iff (reset)
      (mode == STS_REV) |=> !st_q.disc;
  endproperty
  a_disc_rev: assert property (p_disc_rev) else $error("discard flag set in reverse");

  property p_unexp_fwd;
    @(posedge sys_clk) disable iff (reset)
      (mode == STS_FWD) |=> !st_q.unexp;
  endproperty
  a_unexp_fwd: assert property (p_unexp_fwd) else $error("unexpected flag set in forward");

  property p_unexp_set;
    @(posedge sys_clk) disable iff (reset)
      (cpl_in && !cpl_matched && cpl_req_id == own_id && mode == STS_REV) |=> st_q.unexp;
  endproperty
  a_unexp_set: assert property (p_unexp_set) else $error("unexpected flag missed");

  property p_ovr_set;
    @(posedge sys_clk) disable iff (reset) ev_cpl_overrun |=> st_q.ovr;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun flag missed");

  property p_dly_set;
    @(posedge sys_clk) disable iff (reset)
      (req_dn && !fwd_dn && mode == STS_REV) |=> st_q.dly;
  endproperty
  a_dly_set: assert property (p_dly_set) else $error("delayed flag missed");

  property p_all;
    @(posedge sys_clk) disable iff (reset)
      (req_up && st_q.lim_up == 16'hffff) |-> fwd_up;
  endproperty
  a_all: assert property (p_all) else $error("unlimited request blocked");

  property p_clear;
    @(posedge sys_clk) disable iff (reset)
      (cfg_wr && cfg_be[2] && ofs == 8'h84 && cfg_wdata[20] && !ev_cpl_overrun) |=> !st_q.ovr;
  endproperty
  a_clear: assert property (p_clear) else $error("overrun flag not cleared");

  property p_cap;
    @(posedge sys_clk) disable iff (reset)
      (st_q.strap_done && $past(st_q.strap_done)) |-> (st_q.cap133 == $past(st_q.cap133));
  endproperty
  a_cap: assert property (p_cap) else $error("capability bit moved");

  // status reads only once the strap has landed, else the old bit is returned
  sequence s_rd_stat;
    cfg_rd && st_q.strap_done && ofs == `STS_OFS_STATUS;
  endsequence

  sequence s_rd_up;
    cfg_rd && ofs == `STS_OFS_UP;
  endsequence

  sequence s_rd_dn;
    cfg_rd && ofs == `STS_OFS_DN;
  endsequence

  sequence s_rd_pm;
    cfg_rd && ofs == `STS_OFS_PM;
  endsequence

  sequence s_wr_up;
    cfg_wr && ofs == `STS_OFS_UP && cfg_be[3:2] == 2'b11;
  endsequence

  sequence s_wr_dn;
    cfg_wr && ofs == `STS_OFS_DN && cfg_be[3:2] == 2'b11;
  endsequence

  property p_cap_strap;
    @(posedge sys_clk) disable iff (reset)
      (st_q.strap_done && !$past(st_q.strap_done)) |-> (st_q.cap133 == (mode == STS_REV));
  endproperty
  a_cap_strap: assert property (p_cap_strap) else $error("capability strap wrong");

  property p_cap_rd;
    @(posedge sys_clk) disable iff (reset)
      s_rd_stat |=> (cfg_rdata[`STS_BIT_133] == st_q.cap133);
  endproperty
  a_cap_rd: assert property (p_cap_rd) else $error("capability bit misread");

  property p_up_rd;
    @(posedge sys_clk) disable iff (reset)
      s_rd_up |=> (cfg_rdata[15:0] == `STS_CAP_RST);
  endproperty
  a_up_rd: assert property (p_up_rd) else $error("upstream capacity wrong");

  property p_dn_rd;
    @(posedge sys_clk) disable iff (reset)
      s_rd_dn |=> (cfg_rdata[15:0] == `STS_CAP_RST);
  endproperty
  a_dn_rd: assert property (p_dn_rd) else $error("downstream capacity wrong");

  property p_pm_rd;
    @(posedge sys_clk) disable iff (reset)
      s_rd_pm |=> (cfg_rdata == {24'h000000, `STS_PM_ID});
  endproperty
  a_pm_rd: assert property (p_pm_rd) else $error("power id wrong");

  property p_lim_up_wr;
    @(posedge sys_clk) disable iff (reset)
      s_wr_up |=> (st_q.lim_up == $past(wr_lim));
  endproperty
  a_lim_up_wr: assert property (p_lim_up_wr) else $error("upstream limit lost");

  property p_lim_dn_wr;
    @(posedge sys_clk) disable iff (reset)
      s_wr_dn |=> (st_q.lim_dn == $past(wr_lim));
  endproperty
  a_lim_dn_wr: assert property (p_lim_dn_wr) else $error("downstream limit lost");

  property p_dev_cap;
    @(posedge sys_clk) disable iff (reset)
      cfg_wr |=> (dev_num == $past(wr_dev));
  endproperty
  a_dev_cap: assert property (p_dev_cap) else $error("device number not captured");

  property p_dly_fwd;
    @(posedge sys_clk) disable iff (reset)
      (req_up && !fwd_up && mode == STS_FWD) |=> st_q.dly;
  endproperty
  a_dly_fwd: assert property (p_dly_fwd) else $error("delayed flag missed upstream");

  property p_all_dn;
    @(posedge sys_clk) disable iff (reset)
      (req_dn && st_q.lim_dn == `STS_LIM_ALL) |-> fwd_dn;
  endproperty
  a_all_dn: assert property (p_all_dn) else $error("unlimited request blocked");

  // a write of zero, or a lane not enabled, must leave a set flag alone
  property p_keep;
    @(posedge sys_clk) disable iff (reset)
      (cfg_wr && ofs == `STS_OFS_STATUS && !(cfg_be[2] && cfg_wdata[`STS_BIT_DLY]) && st_q.dly)
        |=> st_q.dly;
  endproperty
  a_keep: assert property (p_keep) else $error("delayed flag lost");
endmodule // sts_top
`default_nettype wire

// ==== verif/split_transaction_status_control_tb_top.sv ====
// bench for the split-transaction status block: config reads/writes and events
// assumes sts_top and the far-side model sts_far
`timescale 1ns/100ps
`default_nettype none
module split_transaction_status_control_tb_top
  import sts_pkg::*;
;
  logic        sys_clk, reset, rev_mode, cfg_wr, cfg_rd, go, hit, cfg_rvalid;
  logic        ev_d, cpl_in, cpl_m, ev_o, req_up, req_dn, fwd_up, fwd_dn;
  logic [2:0]  kind;
  logic [1:0]  fw;
  logic [4:0]  dev_sel;
  logic [3:0]  cfg_be;
  logic [15:0] cfg_addr, arg, used, cpl_id, req_size, used_up, used_dn, own_id;
  logic [31:0] cfg_wdata, cfg_rdata;
  int          bad_count, check_count, cyc;

  sts_far far_u (.go(go), .kind(kind), .arg(arg), .hit(hit), .used(used),
    .ev_cpl_discard(ev_d), .cpl_in(cpl_in), .cpl_req_id(cpl_id), .cpl_matched(cpl_m),
    .ev_cpl_overrun(ev_o), .req_up(req_up), .req_dn(req_dn), .req_size(req_size),
    .used_up(used_up), .used_dn(used_dn));
  sts_top dut_u (.sys_clk(sys_clk), .reset(reset), .rev_mode(rev_mode), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .ev_cpl_discard(ev_d), .cpl_in(cpl_in),
    .cpl_req_id(cpl_id), .cpl_matched(cpl_m), .ev_cpl_overrun(ev_o), .req_up(req_up),
    .req_dn(req_dn), .req_size(req_size), .used_up(used_up), .used_dn(used_dn),
    .fwd_up(fwd_up), .fwd_dn(fwd_dn), .own_id(own_id));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      test_done;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= {dev_sel, 3'h0, ofs};
    cfg_wdata <= d;
    cfg_be <= be;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask

  // read data answers one cycle after the request edge
  task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
    @(posedge sys_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= {dev_sel, 3'h0, ofs};
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1;
    check({31'h0, cfg_rvalid}, 32'h1);
    check(cfg_rdata, exp);
  endtask

  // one far-side pulse; forwarding decisions are sampled while it stands
  task automatic ev(input logic [2:0] k, input logic [15:0] a, input logic h);
    @(posedge sys_clk);
    go <= 1'b1;
    kind <= k;
    arg <= a;
    hit <= h;
    #1;
    fw = {fwd_up, fwd_dn};
    @(posedge sys_clk);
    go <= 1'b0;
  endtask

  task automatic do_reset(input logic m);
    reset <= 1'b1;
    rev_mode <= m;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  initial begin
    {cfg_wr, cfg_rd, go, hit, kind, cfg_be, cfg_wdata, arg, cyc} = '0;
    {bad_count, check_count} = '0;
    cfg_addr = 16'h0000;
    used = 16'h0002;
    dev_sel = 5'h1f;
    do_reset(1'b0);
    rd(8'h84, 32'h0000fff8);
    rd(8'h88, 32'h00100010);
    rd(8'h8c, 32'h00100010);
    rd(8'h90, 32'h00000001);
    rd(8'h94, 32'h00000000);
    $display("reset values done");
    dev_sel = 5'h05;
    wr(8'h88, 32'h0004ffff, 4'hf);
    wr(8'h8c, 32'h0003ffff, 4'h3);
    wr(8'h90, 32'hffffffff, 4'hf);
    rd(8'h88, 32'h00040010);
    rd(8'h8c, 32'h00100010);
    rd(8'h90, 32'h00000001);
    check({16'h0, own_id}, 32'h0000ff28);
    $display("register access done");
    ev(3'h3, 16'h0002, 1'b0);
    check({30'h0, fw}, 32'h2);
    ev(3'h3, 16'h0003, 1'b0);
    check({30'h0, fw}, 32'h0);
    ev(3'h4, 16'h000f, 1'b0);
    check({30'h0, fw}, 32'h0);
    ev(3'h4, 16'h000e, 1'b0);
    check({30'h0, fw}, 32'h1);
    rd(8'h84, 32'h0020ff28);
    wr(8'h84, 32'h00200000, 4'hb);
    rd(8'h84, 32'h0020ff28);
    ev(3'h1, 16'h0000, 1'b0);
    ev(3'h2, 16'hff28, 1'b0);
    ev(3'h5, 16'h0000, 1'b0);
    rd(8'h84, 32'h0034ff28);
    wr(8'h84, 32'h00100000, 4'h4);
    rd(8'h84, 32'h0024ff28);
    wr(8'h84, 32'h00240000, 4'h4);
    rd(8'h84, 32'h0000ff28);
    wr(8'h88, 32'hffff0000, 4'hc);
    ev(3'h3, 16'hffff, 1'b0);
    check({30'h0, fw}, 32'h2);
    wr(8'h8c, 32'hffff0000, 4'hc);
    rd(8'h8c, 32'hffff0010);
    ev(3'h4, 16'hffff, 1'b0);
    check({30'h0, fw}, 32'h1);
    $display("forward mode done");
    // reverse mode: 133 bit strapped, discard locked to zero, unexpected completion and blocked downstream request flagged
    do_reset(1'b1);
    dev_sel = 5'h1f;
    rd(8'h84, 32'h0002fff8);
    wr(8'h84, 32'h00020000, 4'h4);
    ev(3'h1, 16'h0000, 1'b0);
    ev(3'h2, 16'hfff8, 1'b1);
    ev(3'h2, 16'hfff7, 1'b0);
    rd(8'h84, 32'h0002fff8);
    ev(3'h2, 16'hfff8, 1'b0);
    ev(3'h4, 16'h000f, 1'b0);
    check({30'h0, fw}, 32'h0);
    rd(8'h84, 32'h002afff8);
    wr(8'h84, 32'h003c0000, 4'h4);
    rd(8'h84, 32'h0002fff8);
    $display("reverse mode done");
    test_done;
  end
endmodule // split_transaction_status_control_tb_top
`default_nettype wire

// ==== verif/sts_far.sv ====
// far-side datapath model: turns one bench pulse into an event or request
// assumes go is a one-cycle pulse driven just after a sys_clk edge
`timescale 1ns/100ps
`default_nettype none
module sts_far
  import sts_pkg::*;
(
  input  wire logic        go,
  input  wire logic [2:0]  kind,
  input  wire logic [15:0] arg,
  input  wire logic        hit,
  input  wire logic [15:0] used,
  output logic             ev_cpl_discard,
  output logic             cpl_in,
  output logic [15:0]      cpl_req_id,
  output logic             cpl_matched,
  output logic             ev_cpl_overrun,
  output logic             req_up,
  output logic             req_dn,
  output logic [15:0]      req_size,
  output logic [15:0]      used_up,
  output logic [15:0]      used_dn
);
  assign ev_cpl_discard = go && kind == 3'h1;
  assign cpl_in         = go && kind == 3'h2;
  // id is only valid with cpl_in; inverted otherwise so a stale id never matches by luck
  assign cpl_req_id     = cpl_in ? arg : ~arg;
  assign cpl_matched    = hit;
  assign ev_cpl_overrun = go && kind == 3'h5;
  assign req_up         = go && kind == 3'h3;
  assign req_dn         = go && kind == 3'h4;
  assign req_size       = arg;
  assign used_up        = used;
  assign used_dn        = used;
endmodule // sts_far
`default_nettype wire
